// ---- core/aoscc_core.sv ----
// aoscc_core: serial control port registers, format decode and datapath reset/recovery control
`default_nettype none
// Operation
// - phase code steps sixty degrees, saturates 660
// - mode register selects lane format and multiplier
// - mode register resets to two-lane DDR bytewise
// - SDR data clock twice the two-lane DDR rate
// - user io two bit0 drops pin pull-down
// - user io three bit3 powers down common-mode
// - recovery off: corruption holds until reset
// - recovery on restores after 31 million cycles
// - recovery setup field resets to 111
// - power-on init; host resets after unstable clock
// - digital reset calibrates, spares control port
module aoscc_core #(
    parameter int RECOVER_CYCLES = aoscc_pkg::RECOVER_CYCLES
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    // serial control port pins
    input  wire logic               sclk,
    input  wire logic               csb_n,
    input  wire logic               sdio_in,
    output logic                    sdio_out,
    output logic                    sdio_oe_n,
    // status from the sampling side
    input  wire logic               clk_glitch,
    // control outputs to datapath and analog
    output aoscc_pkg::aoscc_fmt_s   fmt,
    output logic                    datapath_rst,
    output logic                    calib_busy,
    output logic                    datapath_corrupt,
    output logic                    pulldown_en,
    output logic                    common_mode_voltage_pd,
    output logic [2:0]              vref_sel
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // sclk is sampled like any pin, so it must stay several sys_clk in each level
    logic [1:0] sclk_sy;
    logic [1:0] csb_sy;
    logic [1:0] sdi_sy;
    logic [1:0] gl_sy;
    logic       sclk_d;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_sy <= 2'h0;
            csb_sy  <= 2'h3;
            sdi_sy  <= 2'h0;
            gl_sy   <= 2'h0;
            sclk_d  <= 1'b0;
        end else begin
            sclk_sy <= {sclk_sy[0], sclk};
            csb_sy  <= {csb_sy[0], csb_n};
            sdi_sy  <= {sdi_sy[0], sdio_in};
            gl_sy   <= {gl_sy[0], clk_glitch};
            sclk_d  <= sclk_sy[1];
        end
    end
    // edges are qualified by select so a deselected port never shifts
    wire sel  = !csb_sy[1];
    wire rise = sel && sclk_sy[1] && !sclk_d;
    wire fall = sel && !sclk_sy[1] && sclk_d;

    // ************************************************************
    // serial frame: 16-bit instruction, then 8-bit data
    // ************************************************************
    logic [4:0]  bit_cnt;
    logic [15:0] instr;
    logic [7:0]  wdata;
    logic [7:0]  rshift;
    logic        wr_pulse;
    wire         is_read = instr[15];
    wire  [12:0] addr    = instr[12:0];

    function automatic logic [7:0] rd_mux(
        input logic [12:0] a,
        input logic [7:0]  ph,
        input logic [7:0]  sm,
        input logic [7:0]  pm,
        input logic [7:0]  u2,
        input logic [7:0]  u3,
        input logic [7:0]  cm,
        input logic [7:0]  vr
    );
        unique case (a)
            aoscc_pkg::ADDR_PHASE:    rd_mux = ph & aoscc_pkg::MSK_PHASE;
            aoscc_pkg::ADDR_SER_MODE: rd_mux = sm & aoscc_pkg::MSK_SER_MODE;
            aoscc_pkg::ADDR_PWR_MODE: rd_mux = pm & aoscc_pkg::MSK_PWR_MODE;
            aoscc_pkg::ADDR_USER_IO2: rd_mux = u2 & aoscc_pkg::MSK_USER_IO2;
            aoscc_pkg::ADDR_USER_IO3: rd_mux = u3 & aoscc_pkg::MSK_USER_IO3;
            aoscc_pkg::ADDR_CLK_MON:  rd_mux = cm & aoscc_pkg::MSK_CLK_MON;
            aoscc_pkg::ADDR_VREF:     rd_mux = vr & aoscc_pkg::MSK_VREF;
            default:                  rd_mux = aoscc_pkg::RST_ZERO;
        endcase
    endfunction : rd_mux

    logic [7:0] r_phase;
    logic [7:0] r_ser;
    logic [7:0] r_pwr;
    logic [7:0] r_io2;
    logic [7:0] r_io3;
    logic [7:0] r_cmon;
    logic [7:0] r_vref;

    // only power-on reset touches the control port
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt  <= 5'h00;
            instr    <= 16'h0000;
            wdata    <= 8'h00;
            wr_pulse <= 1'b0;
        end else begin
            wr_pulse <= 1'b0;
            // writes step the address only after the write has used it
            if (wr_pulse) begin
                instr <= instr + 16'h0001;
            end
            if (!sel) begin
                bit_cnt <= 5'h00;
            end else if (rise) begin
                if (bit_cnt < aoscc_pkg::INSTR_BITS) begin
                    instr <= {instr[14:0], sdi_sy[1]};
                end else begin
                    wdata <= {wdata[6:0], sdi_sy[1]};
                end
                if (bit_cnt == aoscc_pkg::FRAME_LAST) begin
                    wr_pulse <= !is_read;
                    bit_cnt  <= aoscc_pkg::INSTR_BITS;
                    // reads step here, ahead of the first fall of the next byte
                    if (is_read) begin
                        instr <= instr + 16'h0001;
                    end
                end else begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end
        end
    end

    // ************************************************************
    // read data path
    // ************************************************************
    // read data shifts out on falling edges once the instruction is in
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rshift    <= 8'h00;
            sdio_oe_n <= 1'b1;
        end else begin
            sdio_oe_n <= !(sel && is_read && bit_cnt >= aoscc_pkg::INSTR_BITS);
            if (fall && bit_cnt == aoscc_pkg::INSTR_BITS) begin
                rshift <= rd_mux(addr, r_phase, r_ser, r_pwr, r_io2, r_io3, r_cmon, r_vref);
            end else if (fall) begin
                rshift <= {rshift[6:0], 1'b0};
            end
        end
    end
    assign sdio_out = rshift[7];

    // ************************************************************
    // register bank
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r_phase <= aoscc_pkg::RST_PHASE;
            r_ser   <= aoscc_pkg::RST_SER_MODE;
            r_pwr   <= aoscc_pkg::RST_ZERO;
            r_io2   <= aoscc_pkg::RST_ZERO;
            r_io3   <= aoscc_pkg::RST_ZERO;
            r_cmon  <= aoscc_pkg::RST_CLK_MON;
            r_vref  <= aoscc_pkg::RST_ZERO;
        end else if (wr_pulse) begin
            unique case (addr)
                aoscc_pkg::ADDR_PHASE:    r_phase <= wdata & aoscc_pkg::MSK_PHASE;
                aoscc_pkg::ADDR_SER_MODE: r_ser   <= wdata & aoscc_pkg::MSK_SER_MODE;
                aoscc_pkg::ADDR_PWR_MODE: r_pwr   <= wdata & aoscc_pkg::MSK_PWR_MODE;
                aoscc_pkg::ADDR_USER_IO2: r_io2   <= wdata & aoscc_pkg::MSK_USER_IO2;
                aoscc_pkg::ADDR_USER_IO3: r_io3   <= wdata & aoscc_pkg::MSK_USER_IO3;
                aoscc_pkg::ADDR_CLK_MON:  r_cmon  <= wdata & aoscc_pkg::MSK_CLK_MON;
                aoscc_pkg::ADDR_VREF:     r_vref  <= wdata & aoscc_pkg::MSK_VREF;
                default:                  ;
            endcase
        end
    end

    // ************************************************************
    // format decode
    // ************************************************************
    function automatic aoscc_pkg::aoscc_fmt_s decode(input logic [7:0] ph, input logic [7:0] sm);
        logic [3:0] code;
        code = (ph[3:0] > aoscc_pkg::PHASE_MAX) ? aoscc_pkg::PHASE_MAX : ph[3:0];
        decode.phase_code = code;
        decode.phase_deg  = 10'(int'(code) * aoscc_pkg::PHASE_STEP_DEG);
        decode.lanes      = 2'h2;
        decode.bitwise    = 1'b0;
        unique case (sm)
            aoscc_pkg::SER_DDR_BIT:  decode.bitwise = 1'b1;
            aoscc_pkg::SER_SDR_BIT:  decode.bitwise = 1'b1;
            aoscc_pkg::SER_DDR_WORD: decode.lanes   = 2'h1;
            default:                 ;
        endcase
        decode.ddr = (sm != aoscc_pkg::SER_SDR_BYTE) && (sm != aoscc_pkg::SER_SDR_BIT);
        // SDR and one-lane run the clock twice as fast
        decode.clk_mult = (decode.ddr && decode.lanes == 2'h2) ? 4'(aoscc_pkg::MULT_DDR2)
                                                                 : 4'(aoscc_pkg::MULT_SLOW);
    endfunction : decode

    // reset format is fixed, so the async reset branch loads a constant
    localparam aoscc_pkg::aoscc_fmt_s FMT_RST = decode(aoscc_pkg::RST_PHASE, aoscc_pkg::RST_SER_MODE);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fmt <= FMT_RST;
        end else begin
            fmt <= decode(r_phase, r_ser);
        end
    end

    // ************************************************************
    // analog controls
    // ************************************************************
    // analog controls
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pulldown_en            <= 1'b1;
            common_mode_voltage_pd <= 1'b0;
            vref_sel               <= 3'h0;
        end else begin
            pulldown_en            <= !r_io2[0];
            common_mode_voltage_pd <= r_io3[3];
            vref_sel               <= r_vref[2:0];
        end
    end

    // ************************************************************
    // init, digital reset, calibration and glitch recovery
    // ************************************************************
    // wide enough for the full recovery count; a bench may shorten it by parameter
    logic [24:0] rec_cnt;
    logic [6:0]  cal_cnt;
    logic        gl_d;
    wire         dig_rst  = (r_pwr[1:0] == aoscc_pkg::PWR_DIGRST);
    wire         rec_on   = (r_cmon[5:3] == aoscc_pkg::RECOV_ON) && (r_cmon[2:0] == aoscc_pkg::RECOV_SETUP);
    wire         gl_rise  = gl_sy[1] && !gl_d;

    // power-on initialisation counts as a calibration
    // digital reset holds datapath and restarts calibration
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cal_cnt      <= 7'(aoscc_pkg::INIT_CYCLES + aoscc_pkg::CALIB_CYCLES);
            datapath_rst <= 1'b1;
            calib_busy   <= 1'b1;
        end else begin
            datapath_rst <= dig_rst;
            if (dig_rst) begin
                cal_cnt <= 7'(aoscc_pkg::CALIB_CYCLES);
            end else if (cal_cnt != 7'h00) begin
                cal_cnt <= cal_cnt - 7'h01;
            end
            calib_busy <= dig_rst || (cal_cnt != 7'h00);
        end
    end

    // recovery on clears after the count
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gl_d             <= 1'b0;
            datapath_corrupt <= 1'b0;
            rec_cnt          <= 25'h000_0000;
        end else begin
            gl_d <= gl_sy[1];
            // a new glitch wins over a clearing reset in the same cycle
            if (gl_rise) begin
                datapath_corrupt <= 1'b1;
                rec_cnt          <= 25'(RECOVER_CYCLES);
            end else if (dig_rst) begin
                datapath_corrupt <= 1'b0;
                rec_cnt          <= 25'h000_0000;
            end else if (datapath_corrupt && rec_on) begin
                if (rec_cnt <= 25'h000_0001) begin
                    datapath_corrupt <= 1'b0;
                end
                rec_cnt <= rec_cnt - 25'h000_0001;
            end
        end
    end
endmodule : aoscc_core
`default_nettype wire

// ---- dv/aoscc_core_asserts.sv ----
// aoscc_core_asserts: port-level checks of the output serializer control
`default_nettype none
module aoscc_core_asserts #(
    parameter int RECOVER_CYCLES = aoscc_pkg::RECOVER_CYCLES
) (
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    // control port
    input wire logic                  sclk,
    input wire logic                  csb_n,
    input wire logic                  sdio_in,
    input wire logic                  sdio_out,
    input wire logic                  sdio_oe_n,
    // status and controls
    input wire logic                  clk_glitch,
    input wire aoscc_pkg::aoscc_fmt_s fmt,
    input wire logic                  datapath_rst,
    input wire logic                  calib_busy,
    input wire logic                  datapath_corrupt,
    input wire logic                  pulldown_en,
    input wire logic                  common_mode_voltage_pd,
    input wire logic [2:0]            vref_sel
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // cycles of calibration outside a held digital reset, saturating so a stuck flag cannot wrap
    logic [7:0] busy_cnt;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= (calib_busy && !datapath_rst) ? busy_cnt + {7'h00, busy_cnt != 8'hff} : 8'h00;
        end
    end
    a_phase_deg: assert property (fmt.phase_deg == 10'(fmt.phase_code) * 10'h03c)
        else $error("phase degrees do not follow the phase code");
    a_phase_sat: assert property (fmt.phase_code <= 4'hb)
        else $error("phase code above the saturation code");
    a_sdr_mult: assert property (!fmt.ddr |-> fmt.clk_mult == 4'h8 && fmt.lanes == 2'h2)
        else $error("single rate mode without eight times clock");
    a_ddr_mult: assert property (fmt.ddr && fmt.lanes == 2'h2 |-> fmt.clk_mult == 4'h4)
        else $error("two-lane double rate mode without four times clock");
    a_word_mult: assert property (fmt.lanes == 2'h1 |-> fmt.ddr && fmt.clk_mult == 4'h8 && !fmt.bitwise)
        else $error("one-lane mode decoded wrongly");
    a_glitch_flag: assert property ($rose(clk_glitch) |-> ##[1:5] datapath_corrupt)
        else $error("clock glitch not flagged");
    a_reset_calib: assert property ($fell(datapath_rst) |-> calib_busy)
        else $error("no calibration after datapath reset");
    a_calib_bound: assert property (busy_cnt <= 8'h64)
        else $error("calibration runs too long");
    a_port_idle: assert property (csb_n [*4] |-> sdio_oe_n)
        else $error("data pin driven while deselected");
    c_digrst: cover property ($rose(datapath_rst));
    c_recover: cover property ($fell(datapath_corrupt));
    c_read: cover property (!sdio_oe_n);
    c_sdr: cover property (!fmt.ddr);
endmodule : aoscc_core_asserts
bind aoscc_core aoscc_core_asserts #(.RECOVER_CYCLES(RECOVER_CYCLES)) aoscc_core_asserts_inst (.sys_clk, .rstn,
    .sclk, .csb_n, .sdio_in, .sdio_out, .sdio_oe_n, .clk_glitch, .fmt, .datapath_rst, .calib_busy,
    .datapath_corrupt, .pulldown_en, .common_mode_voltage_pd, .vref_sel);
`default_nettype wire

// ---- dv/aoscc_pin_model.sv ----
// aoscc_pin_model: shared control data pin with host drive, device drive and pull-down
`default_nettype none
module aoscc_pin_model (
    // host side
    input  wire logic host_oe,
    input  wire logic host_bit,
    // device side
    input  wire logic sdio_out,
    input  wire logic sdio_oe_n,
    input  wire logic pulldown_en,
    // resolved pin
    output logic      sdio
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    always_comb begin
        if (host_oe) begin
            sdio = host_bit;
        end else if (!sdio_oe_n) begin
            sdio = sdio_out;
        end else begin
            // a floating pin reads 0 with pull-down, else the inverse of its last level, never a lucky match
            sdio = pulldown_en ? 1'b0 : ~last;
        end
    end
    always @(sdio) begin
        if (host_oe || !sdio_oe_n) begin
            last <= sdio;
        end
    end
endmodule : aoscc_pin_model
`default_nettype wire

// ---- dv/testbench.sv ----
// testbench: control port register, format, reset and recovery checks
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  sys_clk, rstn, sclk, csb_n, host_oe, host_bit, clk_glitch, sdio;
    logic                  sdio_out, sdio_oe_n, datapath_rst, calib_busy, datapath_corrupt;
    logic                  pulldown_en, common_mode_voltage_pd;
    logic [2:0]            vref_sel;
    aoscc_pkg::aoscc_fmt_s fmt;
    int                    num_errors = 0;
    int                    checked = 0;
    // host sample rate and data clock ceiling in khz; single rate mode is only used at this rate
    localparam int         SAMPLE_KSPS = 62500;
    localparam int         DATA_CLK_MAX_KHZ = 500000;
    // expected {ddr, multiplier, lanes, bitwise} per mode code
    logic [7:0]            modes [5] = '{8'h30, 8'h20, 8'h10, 8'h00, 8'h40};
    logic [7:0]            fexp [5] = '{8'ha4, 8'ha5, 8'h44, 8'h45, 8'hc2};
    wire logic [9:0]       fsel = {2'b00, fmt.ddr, fmt.clk_mult, fmt.lanes, fmt.bitwise};
    aoscc_core #(.RECOVER_CYCLES(50)) aoscc_core_inst (.sys_clk, .rstn, .sclk, .csb_n, .sdio_in(sdio),
        .sdio_out, .sdio_oe_n, .clk_glitch, .fmt, .datapath_rst, .calib_busy, .datapath_corrupt,
        .pulldown_en, .common_mode_voltage_pd, .vref_sel);
    aoscc_pin_model aoscc_pin_model_inst (.host_oe, .host_bit, .sdio_out, .sdio_oe_n, .pulldown_en, .sdio);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic end_sim;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // one 24-bit frame; sclk period 8 cycles, read bits sampled just before each rise
    task automatic xfer(input logic rd_n, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [23:0] f;
        f = {rd_n, 2'b00, a, d};
        csb_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            host_oe = !(rd_n && i < 8);
            host_bit = f[i];
            sclk = 1'b0;
            repeat (4) @(negedge sys_clk);
            if (i < 8) q[i] = sdio;
            sclk = 1'b1;
            repeat (4) @(negedge sys_clk);
        end
        csb_n = 1'b1;
        host_oe = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask : xfer
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, a, d, q);
    endtask : wr
    task automatic rchk(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(1'b1, a, 8'h00, q);
        cmp("register", {2'b00, e}, {2'b00, q});
    endtask : rchk
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        end_sim();
    end
    initial begin
        rstn = 1'b0;
        sclk = 1'b0;
        csb_n = 1'b1;
        host_oe = 1'b0;
        host_bit = 1'b0;
        clk_glitch = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        cmp("calib_busy", 10'h001, {9'h000, calib_busy});
        cmp("fmt", 10'h0a4, fsel);
        cmp("phase_deg", 10'h0b4, fmt.phase_deg);
        rchk(aoscc_pkg::ADDR_SER_MODE, 8'h30);
        rchk(aoscc_pkg::ADDR_CLK_MON, 8'h07);
        rchk(aoscc_pkg::ADDR_PHASE, 8'h03);
        for (int i = 0; i < 5; i++) begin
            wr(aoscc_pkg::ADDR_SER_MODE, modes[i]);
            cmp("fmt", {2'b00, fexp[i]}, fsel);
        end
        for (int c = 0; c < 16; c++) begin
            wr(aoscc_pkg::ADDR_PHASE, 8'(c));
            cmp("phase_deg", 10'((c > 10 ? 11 : c) * 60), fmt.phase_deg);
            rchk(aoscc_pkg::ADDR_PHASE, 8'(c));
        end
        cmp("pulldown_en", 10'h001, {9'h000, pulldown_en});
        wr(aoscc_pkg::ADDR_USER_IO2, 8'hff);
        cmp("pulldown_en", 10'h000, {9'h000, pulldown_en});
        rchk(aoscc_pkg::ADDR_USER_IO2, 8'h01);
        wr(aoscc_pkg::ADDR_USER_IO3, 8'hff);
        cmp("common_mode_voltage_pd", 10'h001, {9'h000, common_mode_voltage_pd});
        rchk(aoscc_pkg::ADDR_USER_IO3, 8'h08);
        wr(aoscc_pkg::ADDR_SER_MODE, 8'hff);
        rchk(aoscc_pkg::ADDR_SER_MODE, 8'h70);
        wr(13'h0200, 8'hff);
        rchk(13'h0200, 8'h00);
        wr(aoscc_pkg::ADDR_SER_MODE, 8'h10);
        cmp("sdr_data_clock", 10'h001, {9'h000, (int'(fmt.clk_mult) * SAMPLE_KSPS) <= DATA_CLK_MAX_KHZ});
        wr(aoscc_pkg::ADDR_VREF, 8'h05);
        cmp("vref_sel", 10'h005, {7'h00, vref_sel});
        wr(aoscc_pkg::ADDR_PWR_MODE, 8'h03);
        cmp("datapath_rst", 10'h001, {9'h000, datapath_rst});
        wr(aoscc_pkg::ADDR_PWR_MODE, 8'h00);
        cmp("datapath_rst", 10'h000, {9'h000, datapath_rst});
        cmp("calib_busy", 10'h001, {9'h000, calib_busy});
        rchk(aoscc_pkg::ADDR_SER_MODE, 8'h10);
        // control port idle while each glitch is raised; writes between them clear the flag and turn recovery on
        repeat (100) @(negedge sys_clk);
        clk_glitch = 1'b1;
        repeat (100) @(negedge sys_clk);
        clk_glitch = 1'b0;
        cmp("corrupt", 10'h001, {9'h000, datapath_corrupt});
        wr(aoscc_pkg::ADDR_PWR_MODE, 8'h03);
        wr(aoscc_pkg::ADDR_PWR_MODE, 8'h00);
        cmp("corrupt", 10'h000, {9'h000, datapath_corrupt});
        wr(aoscc_pkg::ADDR_CLK_MON, 8'h2f);
        clk_glitch = 1'b1;
        repeat (10) @(negedge sys_clk);
        cmp("corrupt", 10'h001, {9'h000, datapath_corrupt});
        repeat (30) @(negedge sys_clk);
        cmp("corrupt", 10'h001, {9'h000, datapath_corrupt});
        repeat (30) @(negedge sys_clk);
        cmp("corrupt", 10'h000, {9'h000, datapath_corrupt});
        clk_glitch = 1'b0;
        end_sim();
    end
endmodule : testbench
`default_nettype wire

// ---- shared/aoscc_pkg.sv ----
// aoscc_pkg: register map, field layout and timing constants of the output serializer control
`default_nettype none
package aoscc_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [12:0] ADDR_PHASE     = 13'h0016;
    localparam logic [12:0] ADDR_SER_MODE  = 13'h0021;
    localparam logic [12:0] ADDR_PWR_MODE  = 13'h0008;
    localparam logic [12:0] ADDR_USER_IO2  = 13'h0101;
    localparam logic [12:0] ADDR_USER_IO3  = 13'h0102;
    localparam logic [12:0] ADDR_CLK_MON   = 13'h0112;
    localparam logic [12:0] ADDR_VREF      = 13'h0114;

    // ************************************************************
    // reset values and writable masks
    // ************************************************************
    localparam logic [7:0] RST_PHASE    = 8'h03;
    localparam logic [7:0] RST_SER_MODE = 8'h30;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_CLK_MON  = 8'h07;
    localparam logic [7:0] MSK_PHASE    = 8'h0f;
    localparam logic [7:0] MSK_SER_MODE = 8'h70;
    localparam logic [7:0] MSK_PWR_MODE = 8'h03;
    localparam logic [7:0] MSK_USER_IO2 = 8'h01;
    localparam logic [7:0] MSK_USER_IO3 = 8'h08;
    localparam logic [7:0] MSK_CLK_MON  = 8'h3f;
    localparam logic [7:0] MSK_VREF     = 8'h07;

    // ************************************************************
    // field codes
    // ************************************************************
    localparam logic [7:0] SER_DDR_BYTE = 8'h30;
    localparam logic [7:0] SER_DDR_BIT  = 8'h20;
    localparam logic [7:0] SER_SDR_BYTE = 8'h10;
    localparam logic [7:0] SER_SDR_BIT  = 8'h00;
    localparam logic [7:0] SER_DDR_WORD = 8'h40;
    localparam logic [3:0] PHASE_MAX    = 4'hb;
    localparam logic [1:0] PWR_NORMAL   = 2'h0;
    localparam logic [1:0] PWR_DIGRST   = 2'h3;
    localparam logic [2:0] RECOV_ON     = 3'h5;
    localparam logic [2:0] RECOV_SETUP  = 3'h7;
    localparam int         PHASE_STEP_DEG = 60;
    localparam int         MULT_DDR2    = 4;
    localparam int         MULT_SLOW    = 8;
    localparam int         WORD_BITS    = 16;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int RECOVER_CYCLES = 31000000;
    localparam int INIT_CYCLES    = 16;
    localparam int CALIB_CYCLES   = 64;
    // control port frame: instruction bits, then the count of the last data bit
    localparam logic [4:0] INSTR_BITS = 5'h10;
    localparam logic [4:0] FRAME_LAST = 5'h17;

    typedef struct packed {
        logic [3:0] phase_code;
        logic [9:0] phase_deg;
        logic       ddr;
        logic [3:0] clk_mult;
        logic [1:0] lanes;
        logic       bitwise;
    } aoscc_fmt_s;
endpackage : aoscc_pkg
`default_nettype wire
